// ---- rtl/apparent_energy_accumulator.sv ----
// apparent energy accumulator with waveform sample registers
`timescale 1ns/10ps
`default_nettype none
`include "apparent_energy_defines.svh"

module apparent_energy_accumulator #(
	parameter int SAMPLE_DIV = `SAMPLE_CYCLES
) (
	// clock and reset
	input  wire logic                             clock,
	input  wire logic                             reset_n,
	// register access
	input  wire apparent_energy_pkg::reg_req_t    reg_req,
	output logic [31:0]                           reg_rdata,
	output logic                                  reg_rvalid,
	// signal path
	input  wire apparent_energy_pkg::sample_in_t  samples,
	input  wire logic [2:0]                       zero_cross,
	// outputs
	output logic [2:0]                            energy_pulse,
	output logic                                  primary_irq_out_n
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	apparent_energy_pkg::state_t st;
	apparent_energy_pkg::state_t nxt;

	logic                    tick;
	logic [47:0]             thr;
	logic                    line_mode;
	logic                    read_reset_enable;
	logic [2:0]              zero_cross_phase_select;
	logic [1:0]              connection_select;
	logic [1:0]              zc_hits;
	logic [15:0]             zc_sum;
	logic                    cycle_done;
	logic                    rd_energy;
	logic [2:0][23:0]        pw;
	logic [2:0][48:0]        sum;
	logic [2:0]              hit;
	logic [2:0]              clr;
	logic [2:0][31:0]        base;
	logic [2:0][31:0]        inc;
	logic                    half_set;
	logic [31:0]             set_bits;
	logic [31:0]             clr_bits;
	logic [23:0]             wsel;

	assign line_mode               = st.lcyc[`LCYC_LVA_BIT];
	assign read_reset_enable       = st.lcyc[`LCYC_READ_RESET_ENABLE_BIT];
	assign zero_cross_phase_select = st.lcyc[`LCYC_ZERO_CROSS_PHASE_SELECT_LSB +: 3];
	assign connection_select       = st.accumulation_config_reg[`ACC_CONNECTION_SELECT_LSB +: 2];

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt        = st;
		nxt.rvalid = 1'b0;
		nxt.pulse  = 3'h0;
		// sample rate enable from the clock divider
		tick       = (st.div == 13'(SAMPLE_DIV - 1));
		nxt.div    = tick ? 13'h0 : st.div + 13'h1;
		thr        = {st.thr_hi, st.thr_lo};

		// half line cycle counting
		zc_hits = 2'(zero_cross[0] & zero_cross_phase_select[0])
		        + 2'(zero_cross[1] & zero_cross_phase_select[1])
		        + 2'(zero_cross[2] & zero_cross_phase_select[2]);
		zc_sum     = st.zc_count + 16'(zc_hits);
		cycle_done = line_mode && (st.half_cycle_count_reg != 16'h0000) && (zc_sum >= st.half_cycle_count_reg);
		nxt.zc_count = (!line_mode || cycle_done) ? 16'h0000 : zc_sum;

		rd_energy = reg_req.rd && (reg_req.addr >= `ADDR_ENERGY_A)
		          && (reg_req.addr <= `ADDR_ENERGY_C);
		half_set  = 1'b0;

		for (int p = 0; p < 3; p++) begin
			// phase b drops out in the three-wire connection
			pw[p]  = (p == 1 && connection_select == `CONNECTION_SELECT_NO_B) ? 24'h000000
			       : samples.apparent[p];
			sum[p] = {1'b0, st.acc1[p]} + {25'h0, pw[p]};
			// a zero threshold would pulse forever, so it stops the pulse stage
			hit[p] = tick && (thr != 48'h000000000000) && (sum[p] >= {1'b0, thr});
			if (tick) begin
				nxt.acc1[p] = hit[p] ? 48'(sum[p] - {1'b0, thr}) : sum[p][47:0];
			end
			nxt.pulse[p] = hit[p];

			// second stage: a pulse arriving with a clearing read is kept
			clr[p]  = !line_mode && read_reset_enable && rd_energy
			        && (reg_req.addr == 8'(`ADDR_ENERGY_A + p));
			base[p] = clr[p] ? 32'h00000000 : st.count[p];
			inc[p]  = base[p] + 32'(st.pulse[p]);
			if (st.pulse[p] && (inc[p][30] != base[p][30])) begin
				half_set = 1'b1;
			end
			if (cycle_done) begin
				nxt.energy[p] = inc[p];
				nxt.count[p]  = 32'h00000000;
			end else begin
				nxt.count[p]  = inc[p];
			end
		end

		// ------------------------------------------------------------
		// waveform capture
		// ------------------------------------------------------------
		if (tick) begin
			for (int p = 0; p < 3; p++) begin
				nxt.wave[2 * p]      = samples.current[p];
				nxt.wave[2 * p + 1]  = samples.voltage[p];
				nxt.wave[7 + p]      = samples.apparent[p];
				nxt.wave[10 + p]     = samples.active[p];
				nxt.wave[13 + p]     = samples.reactive[p];
			end
			nxt.wave[6] = samples.neutral;
		end

		// ------------------------------------------------------------
		// status: a set in the same cycle as a clear wins
		// ------------------------------------------------------------
		set_bits = 32'h00000000;
		set_bits[`STAT_HALF_FULL_BIT] = half_set;
		set_bits[`STAT_READY_BIT]     = tick;
		clr_bits = (reg_req.wr && reg_req.addr == `ADDR_STATUS) ? reg_req.wdata
		         : 32'h00000000;
		nxt.status = (st.status & ~clr_bits) | set_bits;

		// ------------------------------------------------------------
		// register writes
		// ------------------------------------------------------------
		if (reg_req.wr) begin
			unique case (reg_req.addr)
				`ADDR_THR_UPPER:   nxt.thr_hi  = reg_req.wdata[23:0];
				`ADDR_THR_LOWER:   nxt.thr_lo  = reg_req.wdata[23:0];
				`ADDR_MASK:        nxt.mask    = reg_req.wdata;
				`ADDR_LCYC_CFG:    nxt.lcyc    = reg_req.wdata[7:0];
				`ADDR_ACC_CFG:     nxt.accumulation_config_reg = reg_req.wdata[7:0];
				`ADDR_HALF_CYCLES: nxt.half_cycle_count_reg = reg_req.wdata[15:0];
				default: ;
			endcase
		end

		// ------------------------------------------------------------
		// register reads
		// ------------------------------------------------------------
		wsel = st.wave[4'(reg_req.addr - `ADDR_WAVE_FIRST)];
		if (reg_req.rd) begin
			nxt.rvalid = 1'b1;
			if (reg_req.addr >= `ADDR_WAVE_FIRST && reg_req.addr <= `ADDR_WAVE_LAST) begin
				nxt.rdata = {{8{wsel[23]}}, wsel};
			end else begin
				unique case (reg_req.addr)
					`ADDR_THR_UPPER:   nxt.rdata = {8'h00, st.thr_hi};
					`ADDR_THR_LOWER:   nxt.rdata = {8'h00, st.thr_lo};
					`ADDR_ENERGY_A:    nxt.rdata = line_mode ? st.energy[0] : st.count[0];
					`ADDR_ENERGY_B:    nxt.rdata = line_mode ? st.energy[1] : st.count[1];
					`ADDR_ENERGY_C:    nxt.rdata = line_mode ? st.energy[2] : st.count[2];
					`ADDR_STATUS:      nxt.rdata = st.status;
					`ADDR_MASK:        nxt.rdata = st.mask;
					`ADDR_LCYC_CFG:    nxt.rdata = {24'h000000, st.lcyc};
					`ADDR_ACC_CFG:     nxt.rdata = {24'h000000, st.accumulation_config_reg};
					`ADDR_HALF_CYCLES: nxt.rdata = {16'h0000, st.half_cycle_count_reg};
					default:           nxt.rdata = 32'h00000000;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			st         <= '0;
			st.lcyc    <= `RST_LCYC_CFG;
			st.accumulation_config_reg <= `RST_ACC_CFG;
			st.half_cycle_count_reg <= `RST_HALF_CYCLES;
		end else begin
			st <= nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign reg_rdata         = st.rdata;
	assign reg_rvalid        = st.rvalid;
	assign energy_pulse      = st.pulse;
	// status bits are sticky, so the pin holds low until software clears them
	assign primary_irq_out_n = ~|(st.status & st.mask);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	logic [31:0] count_a_seen;
	assign count_a_seen = st.count[0];

	property p_pulse_on_threshold;
		hit[0] |=> energy_pulse[0] ##1 !energy_pulse[0];
	endproperty
	a_pulse_on_threshold: assert property (p_pulse_on_threshold) else $error("no pulse at threshold");

	property p_remainder_below;
		tick && (thr != 48'h0) && (pw[0] < thr) |=> st.acc1[0] < thr;
	endproperty
	a_remainder_below: assert property (p_remainder_below) else $error("remainder not below threshold");

	property p_count_step;
		energy_pulse[0] && !cycle_done && !clr[0] |=> st.count[0] == $past(count_a_seen) + 32'h1;
	endproperty
	a_count_step: assert property (p_count_step) else $error("pulse not counted");

	property p_wrap;
		energy_pulse[0] && count_a_seen == 32'h7fffffff && !cycle_done && !clr[0]
			|=> st.count[0] == 32'h80000000;
	endproperty
	a_wrap: assert property (p_wrap) else $error("count did not wrap negative");

	property p_half_full;
		energy_pulse[0] && count_a_seen == 32'h3fffffff && !clr[0]
			|=> st.status[`STAT_HALF_FULL_BIT];
	endproperty
	a_half_full: assert property (p_half_full) else $error("half-full not flagged");

	property p_irq_low;
		half_set && st.mask[`STAT_HALF_FULL_BIT] && !(reg_req.wr && reg_req.addr == `ADDR_MASK)
			|=> !primary_irq_out_n;
	endproperty
	a_irq_low: assert property (p_irq_low) else $error("interrupt not asserted");

	property p_status_clear;
		reg_req.wr && reg_req.addr == `ADDR_STATUS && reg_req.wdata[`STAT_HALF_FULL_BIT]
			&& !half_set |=> !st.status[`STAT_HALF_FULL_BIT];
	endproperty
	a_status_clear: assert property (p_status_clear) else $error("half-full not cleared");

	property p_read_reset;
		clr[0] && !energy_pulse[0] |=> st.count[0] == 32'h0;
	endproperty
	a_read_reset: assert property (p_read_reset) else $error("read did not reset register");

	property p_phase_b_zero;
		tick && connection_select == `CONNECTION_SELECT_NO_B && st.acc1[1] < thr
			|=> !energy_pulse[1] && st.acc1[1] == $past(st.acc1[1]);
	endproperty
	a_phase_b_zero: assert property (p_phase_b_zero) else $error("phase b not zeroed");

	property p_ready_flag;
		tick |=> st.status[`STAT_READY_BIT] ##0 st.wave[6] == $past(samples.neutral);
	endproperty
	a_ready_flag: assert property (p_ready_flag) else $error("sample not captured");

	property p_sign_extend;
		reg_req.rd && reg_req.addr == `ADDR_WAVE_FIRST
			|=> reg_rvalid && reg_rdata[31:24] == {8{reg_rdata[23]}};
	endproperty
	a_sign_extend: assert property (p_sign_extend) else $error("sample not sign extended");

	property p_line_transfer;
		cycle_done |=> st.count[0] == 32'h0 && st.zc_count == 16'h0;
	endproperty
	a_line_transfer: assert property (p_line_transfer) else $error("line cycle transfer missed");

	c_pulse:     cover property (energy_pulse[0]);
	c_half_full: cover property (half_set);
	c_line_done: cover property (cycle_done);
	c_rd_reset:  cover property (clr[1]);

endmodule
`default_nettype wire

// ---- rtl/apparent_energy_defines.svh ----
// register indices, field positions, reset values and timing counts
`ifndef APPARENT_ENERGY_DEFINES_SVH
`define APPARENT_ENERGY_DEFINES_SVH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define ADDR_THR_UPPER      8'h00
`define ADDR_THR_LOWER      8'h01
`define ADDR_ENERGY_A       8'h02
`define ADDR_ENERGY_B       8'h03
`define ADDR_ENERGY_C       8'h04
`define ADDR_STATUS         8'h05
`define ADDR_MASK           8'h06
`define ADDR_LCYC_CFG       8'h07
`define ADDR_ACC_CFG        8'h08
`define ADDR_HALF_CYCLES    8'h09
`define ADDR_WAVE_FIRST     8'h0a
`define ADDR_WAVE_LAST      8'h19

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define STAT_HALF_FULL_BIT  4
`define STAT_READY_BIT      17
`define LCYC_LVA_BIT        2
`define LCYC_ZERO_CROSS_PHASE_SELECT_LSB      3
`define LCYC_READ_RESET_ENABLE_BIT    6
`define ACC_CONNECTION_SELECT_LSB      4
`define CONNECTION_SELECT_NO_B         2'h1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_HALF_CYCLES     16'hffff
`define RST_LCYC_CFG        8'h38
`define RST_ACC_CFG         8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLOCK_PERIOD_NS     25
`define SAMPLE_PERIOD_NS    125000
`define SAMPLE_CYCLES       (`SAMPLE_PERIOD_NS / `CLOCK_PERIOD_NS)

`endif

// ---- rtl/apparent_energy_pkg.sv ----
// types shared by the apparent energy accumulator and its bench
package apparent_energy_pkg;

	// ----------------------------------------------------------------
	// register access port
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} reg_req_t;

	// ----------------------------------------------------------------
	// per-sample inputs from the signal path
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0][23:0] current;
		logic [2:0][23:0] voltage;
		logic [23:0]      neutral;
		logic [2:0][23:0] apparent;
		logic [2:0][23:0] active;
		logic [2:0][23:0] reactive;
	} sample_in_t;

	// ----------------------------------------------------------------
	// complete block state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [12:0]       div;
		logic [2:0][47:0]  acc1;
		logic [2:0]        pulse;
		logic [2:0][31:0]  count;
		logic [2:0][31:0]  energy;
		logic [23:0]       thr_hi;
		logic [23:0]       thr_lo;
		logic [31:0]       status;
		logic [31:0]       mask;
		logic [7:0]        lcyc;
		logic [7:0]        accumulation_config_reg;
		logic [15:0]       half_cycle_count_reg;
		logic [15:0]       zc_count;
		logic [15:0][23:0] wave;
		logic [31:0]       rdata;
		logic              rvalid;
	} state_t;

endpackage

// ---- dv/host_model.sv ----
// host side model that reaches the registers one strobe at a time
`timescale 1ns/10ps
`default_nettype none

module host_model (
	// clock
	input  wire logic                     clock,
	// register access towards the device
	output var apparent_energy_pkg::reg_req_t reg_req,
	input  wire logic [31:0]              reg_rdata,
	input  wire logic                     reg_rvalid
);
	initial begin
		reg_req = '0;
	end

	// released address and data show the inverse of their last value, not a stale copy
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock);
		#1;
		reg_req.wr = 1'b1;
		reg_req.addr = a;
		reg_req.wdata = v;
		@(posedge clock);
		#1;
		reg_req.wr = 1'b0;
		reg_req.addr = ~reg_req.addr;
		reg_req.wdata = ~reg_req.wdata;
	endtask

	// answer must come exactly one cycle after the strobe, else unknown is handed back
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clock);
		#1;
		reg_req.rd = 1'b1;
		reg_req.addr = a;
		@(posedge clock);
		#1;
		reg_req.rd = 1'b0;
		reg_req.addr = ~reg_req.addr;
		v = (reg_rvalid === 1'b1) ? reg_rdata : 32'hxxxxxxxx;
	endtask
endmodule

`default_nettype wire

// ---- dv/apparent_energy_accumulator_tb.sv ----
// self-checking bench for the apparent energy accumulator
`timescale 1ns/10ps
`default_nettype none
`include "apparent_energy_defines.svh"

module apparent_energy_accumulator_tb;
	localparam int DIV = 20;
	logic                            clock;
	logic                            reset_n;
	apparent_energy_pkg::reg_req_t   reg_req;
	apparent_energy_pkg::sample_in_t samples;
	logic [31:0]                     reg_rdata;
	logic                            reg_rvalid;
	logic [2:0]                      zero_cross;
	logic [2:0]                      energy_pulse;
	logic                            primary_irq_out_n;
	int                              n_errors = 0;
	int                              checked = 0;
	int                              cycles = 0;
	logic [31:0]                     d;
	logic [31:0]                     x;
	logic [23:0]                     w;
	int                              n_pulse_c = 0;

	apparent_energy_accumulator #(.SAMPLE_DIV(DIV)) dut (
		.clock(clock),
		.reset_n(reset_n),
		.reg_req(reg_req),
		.reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid),
		.samples(samples),
		.zero_cross(zero_cross),
		.energy_pulse(energy_pulse),
		.primary_irq_out_n(primary_irq_out_n)
	);

	host_model host (
		.clock(clock),
		.reg_req(reg_req),
		.reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid)
	);

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic stop_test();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked = checked + 1;
		if (got !== exp) begin
			n_errors = n_errors + 1;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		host.rd(a, v);
		chk(v, exp);
	endtask

	task automatic zc(input logic [2:0] b);
		@(posedge clock);
		#1 zero_cross = b;
		@(posedge clock);
		#1 zero_cross = 3'h0;
	endtask

	function automatic logic [23:0] wv(input int k);
		return k[0] ? (24'h800000 | 24'(k)) : (24'h000100 | 24'(k));
	endfunction

	// pulses counted half a cycle away from the edge that launches them
	always @(negedge clock) begin
		if (energy_pulse[2] === 1'b1) begin
			n_pulse_c <= n_pulse_c + 1;
		end
	end

	// the whole run is under a thousand cycles; a hang is cut well past that
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_errors = n_errors + 1;
			stop_test();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		reset_n = 1'b0;
		samples = '0;
		zero_cross = 3'h0;
		repeat (16) @(posedge clock);
		#1 reset_n = 1'b1;
		rc(`ADDR_STATUS, 32'h00000000);
		rc(`ADDR_LCYC_CFG, 32'h00000038);
		rc(`ADDR_ACC_CFG, 32'h00000000);
		rc(`ADDR_HALF_CYCLES, 32'h0000ffff);
		rc(8'h20, 32'h00000000);
		host.wr(`ADDR_THR_UPPER, 32'hff000000);
		rc(`ADDR_THR_UPPER, 32'h00000000);
		host.wr(`ADDR_THR_LOWER, 32'hab000064);
		rc(`ADDR_THR_LOWER, 32'h00000064);
		// steady powers; 60 against 100 leaves a remainder on four ticks in five
		samples.apparent[0] = 24'd60;
		samples.apparent[1] = 24'd40;
		samples.apparent[2] = 24'd100;
		host.wr(`ADDR_ACC_CFG, 32'h00000010);
		host.wr(`ADDR_LCYC_CFG, 32'h00000078);
		host.wr(`ADDR_ENERGY_A, 32'h12345678);
		host.rd(`ADDR_ENERGY_A, d);
		host.rd(`ADDR_ENERGY_B, d);
		host.rd(`ADDR_ENERGY_C, d);
		// each register is read again exactly ten ticks after its own clearing read
		repeat (194) @(posedge clock);
		rc(`ADDR_ENERGY_A, 32'd6);
		rc(`ADDR_ENERGY_B, 32'd0);
		rc(`ADDR_ENERGY_C, 32'd10);
		chk(32'(n_pulse_c), 32'd11);
		host.wr(`ADDR_ACC_CFG, 32'h00000000);
		host.rd(`ADDR_ENERGY_B, d);
		repeat (198) @(posedge clock);
		rc(`ADDR_ENERGY_B, 32'd4);
		// line-cycle mode, phases a and c counted, read-reset kept off
		host.wr(`ADDR_HALF_CYCLES, 32'h00000004);
		host.wr(`ADDR_LCYC_CFG, 32'h0000002c);
		repeat (4) zc(3'h1);
		host.rd(`ADDR_ENERGY_A, x);
		zc(3'h1);
		zc(3'h2);
		zc(3'h4);
		zc(3'h4);
		rc(`ADDR_ENERGY_A, x);
		repeat (186) @(posedge clock);
		zc(3'h1);
		rc(`ADDR_ENERGY_A, 32'd6);
		// sample-ready flag through the mask onto the interrupt
		host.wr(`ADDR_STATUS, 32'h00020000);
		host.wr(`ADDR_MASK, 32'h00020000);
		for (int i = 0; i < 2 * DIV && primary_irq_out_n !== 1'b0; i++) begin
			@(posedge clock);
		end
		chk({31'h0, primary_irq_out_n}, 32'h0);
		rc(`ADDR_STATUS, 32'h00020000);
		host.wr(`ADDR_STATUS, 32'h00020000);
		chk({31'h0, primary_irq_out_n}, 32'h1);
		host.wr(`ADDR_MASK, 32'h00000000);
		// waveform registers, odd ones negative
		for (int p = 0; p < 3; p++) begin
			samples.current[p] = wv(2 * p);
			samples.voltage[p] = wv(2 * p + 1);
			samples.apparent[p] = wv(7 + p);
			samples.active[p] = wv(10 + p);
			samples.reactive[p] = wv(13 + p);
		end
		samples.neutral = wv(6);
		repeat (DIV + 5) @(posedge clock);
		for (int k = 0; k < 16; k++) begin
			w = wv(k);
			rc(8'(`ADDR_WAVE_FIRST + k), {{8{w[23]}}, w});
		end
		stop_test();
	end
endmodule

`default_nettype wire
